/* rtl/rail_irq_mask_and_load_meas_regs.sv */
// Purpose: Boost and monitor interrupt masks plus the load-current measurement registers.
// Assumes: Register reads and writes come from the serial front end on mclk, one cycle each.
// Notes: Flag and status registers live elsewhere; this bank drives their set pulses and levels.
// How it works
// [R1] Boost mask bit 3 set blocks the power-good-lost interrupt.
// [R2] Boost mask bit 2 set blocks the power-good-reached interrupt.
// [R3] Boost mask bit 0 set blocks the current-limit interrupt.
// [R4] Boost power-good status follows the real level whatever the masks.
// [R5] Boost current-limit status follows the live condition whatever the mask.
// [R6] Monitor mask bit 5 set blocks second monitor power-good-lost interrupt.
// [R7] Monitor mask bit 4 set blocks second monitor power-good-reached interrupt.
// [R8] Monitor mask bit 3 set blocks first monitor power-good-lost interrupt.
// [R9] Monitor mask bit 2 set blocks first monitor power-good-reached interrupt.
// [R10] Monitor mask bit 1 set blocks analog supply power-good-lost interrupt.
// [R11] Monitor mask bit 0 set blocks analog supply power-good-reached interrupt.
// [R12] Monitor masks never change monitor status bits.
// [R13] Mask defaults load from one-time-programmable memory at initialisation.
// [R14] Select low bit picks the converter; bit one is ignored.
// [R15] Every select write starts a measurement, even with an unchanged value.
// [R16] High result bit 0 is the result MSB, 20 mA per LSB.
// [R17] Low result register holds the eight low bits of the result.
// [R18] A finished measurement raises the ready interrupt unless masked.
// [R19] Both result fields update together only when a measurement completes.
`timescale 1ns/100ps
`default_nettype none
module rail_irq_mask_and_load_meas_regs (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Register access from the serial front end.
  input wire rail_mask_pkg::reg_req_s regReq,
  output logic [7:0] regRdata,
  output logic regHit,
  // Defaults from one-time-programmable memory.
  input wire logic otpLoad,
  input wire logic [7:0] otpBoostMask,
  input wire logic [7:0] otpMonitorMask,
  // Analog monitor levels, asynchronous to mclk.
  input wire logic stepUpPgLevel,
  input wire logic stepUpCurlimLevel,
  input wire logic analogSupplyLevel,
  input wire logic extMon1Level,
  input wire logic extMon2Level,
  // Filtered status for the status registers.
  output logic stepUpPgState,
  output logic stepUpCurlimState,
  output logic analogSupplyState,
  output logic extMon1State,
  output logic extMon2State,
  // Interrupt flag set pulses.
  output logic stepUpPgIrq,
  output logic stepUpCurlimIrq,
  output logic analogSupplyIrq,
  output logic extMon1Irq,
  output logic extMon2Irq,
  // Load-current measurement engine.
  input wire logic measReadyIrqMask,
  input wire rail_mask_pkg::meas_res_s measRes,
  output logic measStart,
  output logic measConv,
  output logic measReadyIrq
);

  typedef struct packed {
    logic [7:0] boostMask;
    logic [7:0] monitorMask;
    logic [7:0] select;
    logic [7:0] rdata;
    logic hit;
    logic startReq;
  } bank_state_s;

  bank_state_s st_r;
  bank_state_s st_nxt;
  logic [rail_mask_pkg::NUM_CHAN-1:0] levelIn;
  logic [rail_mask_pkg::NUM_CHAN-1:0] riseMask;
  logic [rail_mask_pkg::NUM_CHAN-1:0] fallMask;
  logic [rail_mask_pkg::NUM_CHAN-1:0] stateVec;
  logic [rail_mask_pkg::NUM_CHAN-1:0] irqVec;
  logic [8:0] result;

  // Channel wiring; the current limit only interrupts on onset, so its fall is always masked.
  always_comb begin
    levelIn = '0;
    riseMask = '0;
    fallMask = '0;
    levelIn[rail_mask_pkg::CH_STEP_UP_PG] = stepUpPgLevel;
    levelIn[rail_mask_pkg::CH_STEP_UP_CURLIM] = stepUpCurlimLevel;
    levelIn[rail_mask_pkg::CH_ANALOG_SUPPLY] = analogSupplyLevel;
    levelIn[rail_mask_pkg::CH_EXT_MON1] = extMon1Level;
    levelIn[rail_mask_pkg::CH_EXT_MON2] = extMon2Level;
    riseMask[rail_mask_pkg::CH_STEP_UP_PG] = st_r.boostMask[rail_mask_pkg::STEP_UP_PG_RISE_MASK_BIT]; // R2
    fallMask[rail_mask_pkg::CH_STEP_UP_PG] = st_r.boostMask[rail_mask_pkg::STEP_UP_PG_FALL_MASK_BIT]; // R1
    riseMask[rail_mask_pkg::CH_STEP_UP_CURLIM] = st_r.boostMask[rail_mask_pkg::STEP_UP_CURLIM_MASK_BIT]; // R3
    fallMask[rail_mask_pkg::CH_STEP_UP_CURLIM] = 1'b1;
    riseMask[rail_mask_pkg::CH_ANALOG_SUPPLY] = st_r.monitorMask[rail_mask_pkg::ANALOG_SUPPLY_RISE_MASK_BIT]; // R11
    fallMask[rail_mask_pkg::CH_ANALOG_SUPPLY] = st_r.monitorMask[rail_mask_pkg::ANALOG_SUPPLY_FALL_MASK_BIT]; // R10
    riseMask[rail_mask_pkg::CH_EXT_MON1] = st_r.monitorMask[rail_mask_pkg::EXT_MON1_RISE_MASK_BIT]; // R9
    fallMask[rail_mask_pkg::CH_EXT_MON1] = st_r.monitorMask[rail_mask_pkg::EXT_MON1_FALL_MASK_BIT]; // R8
    riseMask[rail_mask_pkg::CH_EXT_MON2] = st_r.monitorMask[rail_mask_pkg::EXT_MON2_RISE_MASK_BIT]; // R7
    fallMask[rail_mask_pkg::CH_EXT_MON2] = st_r.monitorMask[rail_mask_pkg::EXT_MON2_FALL_MASK_BIT]; // R6
  end

  // Edge detection and masking for all monitored channels.
  pg_edge_gate u_edge (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .levelIn(levelIn),
    .riseMask(riseMask),
    .fallMask(fallMask),
    .stateOut(stateVec),
    .irqPulse(irqVec)
  );

  // Measurement sequencing and result hold.
  load_meas_seq u_meas (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .startReq(st_r.startReq),
    .convSel(st_r.select[rail_mask_pkg::SELECT_CONV_BIT]),
    .measReadyIrqMask(measReadyIrqMask),
    .measRes(measRes),
    .measStart(measStart),
    .measConv(measConv),
    .result(result),
    .measReadyIrq(measReadyIrq)
  );

  // Register writes, OTP default load and read data.
  // OTP load wins over a host write in the same cycle, since it only happens during
  // initialisation when the host should not be talking yet.
  always_comb begin
    st_nxt = st_r;
    st_nxt.startReq = 1'b0;
    if (regReq.we) begin
      case (regReq.addr)
        rail_mask_pkg::BOOST_IRQ_MASK_ADDR: st_nxt.boostMask = regReq.wdata;
        rail_mask_pkg::MONITOR_IRQ_MASK_ADDR: st_nxt.monitorMask = regReq.wdata;
        rail_mask_pkg::LOAD_MEAS_SELECT_ADDR: begin
          st_nxt.select = regReq.wdata;
          st_nxt.startReq = 1'b1; // R15
        end
        default: begin
          st_nxt.select = st_r.select;
        end
      endcase
    end
    if (otpLoad) begin
      st_nxt.boostMask = otpBoostMask; // R13
      st_nxt.monitorMask = otpMonitorMask; // R13
    end
    if (regReq.re) begin
      st_nxt.hit = 1'b1;
      case (regReq.addr)
        rail_mask_pkg::BOOST_IRQ_MASK_ADDR: st_nxt.rdata = st_r.boostMask;
        rail_mask_pkg::MONITOR_IRQ_MASK_ADDR: st_nxt.rdata = st_r.monitorMask;
        rail_mask_pkg::LOAD_MEAS_SELECT_ADDR: st_nxt.rdata = st_r.select;
        rail_mask_pkg::LOAD_RESULT_HIGH_ADDR: st_nxt.rdata = {7'h00, result[rail_mask_pkg::RESULT_MSB_BIT]}; // R16
        rail_mask_pkg::LOAD_RESULT_LOW_ADDR: st_nxt.rdata = result[7:0]; // R17
        default: begin
          st_nxt.rdata = 8'h00;
          st_nxt.hit = 1'b0;
        end
      endcase
    end
  end

  // State register; a low enable freezes everything.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '{boostMask: rail_mask_pkg::BOOST_IRQ_MASK_RST, monitorMask: rail_mask_pkg::MONITOR_IRQ_MASK_RST,
                select: rail_mask_pkg::LOAD_MEAS_SELECT_RST, rdata: 8'h00, hit: 1'b0, startReq: 1'b0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs, all from flip-flops here or in the two submodules.
  assign regRdata = st_r.rdata;
  assign regHit = st_r.hit;
  assign stepUpPgState = stateVec[rail_mask_pkg::CH_STEP_UP_PG]; // R4
  assign stepUpCurlimState = stateVec[rail_mask_pkg::CH_STEP_UP_CURLIM]; // R5
  assign analogSupplyState = stateVec[rail_mask_pkg::CH_ANALOG_SUPPLY]; // R12
  assign extMon1State = stateVec[rail_mask_pkg::CH_EXT_MON1];
  assign extMon2State = stateVec[rail_mask_pkg::CH_EXT_MON2];
  assign stepUpPgIrq = irqVec[rail_mask_pkg::CH_STEP_UP_PG];
  assign stepUpCurlimIrq = irqVec[rail_mask_pkg::CH_STEP_UP_CURLIM];
  assign analogSupplyIrq = irqVec[rail_mask_pkg::CH_ANALOG_SUPPLY];
  assign extMon1Irq = irqVec[rail_mask_pkg::CH_EXT_MON1];
  assign extMon2Irq = irqVec[rail_mask_pkg::CH_EXT_MON2];

endmodule : rail_irq_mask_and_load_meas_regs
`default_nettype wire

/* rtl/rail_mask_pkg.sv */
// Purpose: Shared constants and carrier types for the rail mask and load measurement register slice.
// Assumes: Register access arrives from the serial register front end on the mclk domain.
// Notes: Offsets are the printed register addresses of the serial register map.
package rail_mask_pkg;

  // Register addresses.
  localparam logic [7:0] BOOST_IRQ_MASK_ADDR = 8'h2c;
  localparam logic [7:0] MONITOR_IRQ_MASK_ADDR = 8'h2d;
  localparam logic [7:0] LOAD_MEAS_SELECT_ADDR = 8'h2e;
  localparam logic [7:0] LOAD_RESULT_HIGH_ADDR = 8'h2f;
  localparam logic [7:0] LOAD_RESULT_LOW_ADDR = 8'h30;

  // Reset values.
  localparam logic [7:0] BOOST_IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] MONITOR_IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] LOAD_MEAS_SELECT_RST = 8'h00;
  localparam logic [8:0] LOAD_RESULT_RST = 9'h000;

  // Field positions in the boost mask register.
  localparam int STEP_UP_PG_FALL_MASK_BIT = 3;
  localparam int STEP_UP_PG_RISE_MASK_BIT = 2;
  localparam int STEP_UP_CURLIM_MASK_BIT = 0;

  // Field positions in the monitor mask register.
  localparam int EXT_MON2_FALL_MASK_BIT = 5;
  localparam int EXT_MON2_RISE_MASK_BIT = 4;
  localparam int EXT_MON1_FALL_MASK_BIT = 3;
  localparam int EXT_MON1_RISE_MASK_BIT = 2;
  localparam int ANALOG_SUPPLY_FALL_MASK_BIT = 1;
  localparam int ANALOG_SUPPLY_RISE_MASK_BIT = 0;

  // Converter select field and result high bit position.
  localparam int SELECT_CONV_BIT = 0;
  localparam int RESULT_MSB_BIT = 8;

  // Monitored channel count and channel indices.
  localparam int NUM_CHAN = 5;
  localparam int CH_STEP_UP_PG = 0;
  localparam int CH_STEP_UP_CURLIM = 1;
  localparam int CH_ANALOG_SUPPLY = 2;
  localparam int CH_EXT_MON1 = 3;
  localparam int CH_EXT_MON2 = 4;

  // Register access request from the serial front end.
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Result handed back by the measurement engine.
  typedef struct packed {
    logic done;
    logic [8:0] value;
  } meas_res_s;

  // Measurement sequencer states.
  typedef enum logic {MEAS_IDLE, MEAS_BUSY} meas_state_e;

endpackage : rail_mask_pkg

/* rtl/pg_edge_gate.sv */
// Purpose: Synchronises monitor levels and turns their edges into masked interrupt pulses.
// Assumes: Monitor levels come from analog comparators outside the mclk domain.
// Notes: Status follows the filtered level regardless of masks; masks only gate the pulses.
`timescale 1ns/100ps
`default_nettype none
module pg_edge_gate (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Raw levels and masks, one bit per channel.
  input wire logic [rail_mask_pkg::NUM_CHAN-1:0] levelIn,
  input wire logic [rail_mask_pkg::NUM_CHAN-1:0] riseMask,
  input wire logic [rail_mask_pkg::NUM_CHAN-1:0] fallMask,
  // Filtered state and one-cycle interrupt pulses.
  output logic [rail_mask_pkg::NUM_CHAN-1:0] stateOut,
  output logic [rail_mask_pkg::NUM_CHAN-1:0] irqPulse
);

  typedef struct packed {
    logic [rail_mask_pkg::NUM_CHAN-1:0] sync1;
    logic [rail_mask_pkg::NUM_CHAN-1:0] sync2;
    logic [rail_mask_pkg::NUM_CHAN-1:0] sync3;
    logic [rail_mask_pkg::NUM_CHAN-1:0] level;
    logic [rail_mask_pkg::NUM_CHAN-1:0] primed;
    logic [rail_mask_pkg::NUM_CHAN-1:0] pulse;
    logic [2:0] fill;
  } edge_state_s;

  edge_state_s st_r;
  edge_state_s st_nxt;
  logic [rail_mask_pkg::NUM_CHAN-1:0] agree;
  logic [rail_mask_pkg::NUM_CHAN-1:0] risen;
  logic [rail_mask_pkg::NUM_CHAN-1:0] fallen;

  // Per channel: a change counts only once the second and third stages agree.
  // Agreement is ignored until real samples fill all three stages, and the first
  // one after that only primes the level, so a rail already good at reset
  // release does not fire a false rise event from the cleared stages.
  genvar gi;
  generate
    for (gi = 0; gi < rail_mask_pkg::NUM_CHAN; gi = gi + 1) begin : g_chan
      assign agree[gi] = st_r.fill[2] & (st_r.sync2[gi] == st_r.sync3[gi]);
      assign risen[gi] = agree[gi] & st_r.primed[gi] & st_r.sync3[gi] & ~st_r.level[gi];
      assign fallen[gi] = agree[gi] & st_r.primed[gi] & ~st_r.sync3[gi] & st_r.level[gi];
    end
  endgenerate

  // Next-state logic.
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = levelIn;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    st_nxt.fill = {st_r.fill[1:0], 1'b1};
    st_nxt.level = (st_r.level & ~agree) | (st_r.sync3 & agree); // R4 R5 R12
    st_nxt.primed = st_r.primed | agree;
    st_nxt.pulse = (risen & ~riseMask) | (fallen & ~fallMask); // R1 R2 R3 R6 R7 R8 R9 R10 R11
  end

  // State register; a low enable freezes everything.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign stateOut = st_r.level;
  assign irqPulse = st_r.pulse;

endmodule : pg_edge_gate
`default_nettype wire

/* rtl/load_meas_seq.sv */
// Purpose: Sequences one load-current measurement per select write and holds the result.
// Assumes: The measurement engine answers with a one-cycle done and the nine-bit average.
// Notes: A new start while busy restarts the engine; the old result stays until done.
`timescale 1ns/100ps
`default_nettype none
module load_meas_seq (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Start request from the register bank.
  input wire logic startReq,
  input wire logic convSel,
  input wire logic measReadyIrqMask,
  // Measurement engine handshake.
  input wire rail_mask_pkg::meas_res_s measRes,
  output logic measStart,
  output logic measConv,
  // Held result and ready pulse.
  output logic [8:0] result,
  output logic measReadyIrq
);

  typedef struct packed {
    rail_mask_pkg::meas_state_e state;
    logic start;
    logic conv;
    logic [8:0] result;
    logic irq;
  } seq_state_s;

  seq_state_s st_r;
  seq_state_s st_nxt;

  // Start wins over a done in the same cycle, because the done belongs to
  // the measurement that the new write has just replaced. A done in the next
  // cycle, while the start is still on its way to the engine, is stale too.
  always_comb begin
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.irq = 1'b0;
    case (st_r.state)
      rail_mask_pkg::MEAS_IDLE: begin
        if (startReq) begin
          st_nxt.state = rail_mask_pkg::MEAS_BUSY; // R15
          st_nxt.start = 1'b1; // R15
          st_nxt.conv = convSel; // R14
        end
      end
      rail_mask_pkg::MEAS_BUSY: begin
        if (startReq) begin
          st_nxt.start = 1'b1; // R15
          st_nxt.conv = convSel; // R14
        end else if (measRes.done && !st_r.start) begin
          st_nxt.state = rail_mask_pkg::MEAS_IDLE;
          st_nxt.result = measRes.value; // R16 R17 R19
          st_nxt.irq = ~measReadyIrqMask; // R18
        end
      end
      default: begin
        st_nxt.state = rail_mask_pkg::MEAS_IDLE;
      end
    endcase
  end

  // State register; a low enable freezes everything.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '{state: rail_mask_pkg::MEAS_IDLE, start: 1'b0, conv: 1'b0,
                result: rail_mask_pkg::LOAD_RESULT_RST, irq: 1'b0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign measStart = st_r.start;
  assign measConv = st_r.conv;
  assign result = st_r.result;
  assign measReadyIrq = st_r.irq;

endmodule : load_meas_seq
`default_nettype wire

/* verif/rail_regs_checker.sv */
// Purpose: Port assertions for the rail mask and load measurement bank.
// Assumes: ce stays high; monitor levels are held for several cycles.
// Notes: Monitor timing allows a small window for synchroniser phase.
`timescale 1ns/100ps
`default_nettype none
module rail_regs_checker (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Register and measurement side.
  input wire rail_mask_pkg::reg_req_s regReq,
  input wire logic measReadyIrqMask,
  input wire rail_mask_pkg::meas_res_s measRes,
  input wire logic measStart,
  input wire logic measConv,
  input wire logic measReadyIrq,
  // Monitor levels, states and pulses.
  input wire logic stepUpPgLevel,
  input wire logic stepUpCurlimLevel,
  input wire logic extMon1Level,
  input wire logic stepUpPgState,
  input wire logic stepUpCurlimState,
  input wire logic extMon1State,
  input wire logic analogSupplyState,
  input wire logic extMon2State,
  input wire logic stepUpPgIrq,
  input wire logic stepUpCurlimIrq,
  input wire logic analogSupplyIrq,
  input wire logic extMon1Irq,
  input wire logic extMon2Irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // A select write must start the engine two edges later.
  property p_sel_start;
    (ce && regReq.we && regReq.addr == 8'h2e) |-> ##2 measStart;
  endproperty
  a_sel_start: assert property (p_sel_start)
    else $error("select write gave no start");
  // Only the low select bit picks the converter.
  property p_conv;
    (ce && regReq.we && regReq.addr == 8'h2e) |-> ##2 (measConv == $past(regReq.wdata[0], 2));
  endproperty
  a_conv: assert property (p_conv)
    else $error("wrong converter chosen");
  // A ready pulse needs an unmasked completion just before it.
  property p_ready;
    measReadyIrq |-> ($past(measRes.done) && !$past(measReadyIrqMask));
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready pulse without unmasked completion");
  // Interrupt pulses only come with an accepted state change.
  property p_pg_irq;
    stepUpPgIrq |-> $changed(stepUpPgState);
  endproperty
  a_pg_irq: assert property (p_pg_irq)
    else $error("power-good pulse without state change");
  property p_curlim_irq;
    stepUpCurlimIrq |-> $rose(stepUpCurlimState);
  endproperty
  a_curlim_irq: assert property (p_curlim_irq)
    else $error("current-limit pulse without onset");
  property p_ana_irq;
    analogSupplyIrq |-> $changed(analogSupplyState);
  endproperty
  a_ana_irq: assert property (p_ana_irq)
    else $error("analog supply pulse without state change");
  property p_mon1_irq;
    extMon1Irq |-> $changed(extMon1State);
  endproperty
  a_mon1_irq: assert property (p_mon1_irq)
    else $error("first monitor pulse without state change");
  property p_mon2_irq;
    extMon2Irq |-> $changed(extMon2State);
  endproperty
  a_mon2_irq: assert property (p_mon2_irq)
    else $error("second monitor pulse without state change");
  // States track a level that has settled, whatever the masks hold.
  property p_pg_follow;
    ($changed(stepUpPgLevel) ##1 $stable(stepUpPgLevel)[*3]) |-> ##[0:2] (stepUpPgState == stepUpPgLevel);
  endproperty
  a_pg_follow: assert property (p_pg_follow)
    else $error("power-good state does not follow level");
  property p_curlim_follow;
    ($changed(stepUpCurlimLevel) ##1 $stable(stepUpCurlimLevel)[*3])
      |-> ##[0:2] (stepUpCurlimState == stepUpCurlimLevel);
  endproperty
  a_curlim_follow: assert property (p_curlim_follow)
    else $error("current-limit state does not follow level");
  property p_mon1_follow;
    ($changed(extMon1Level) ##1 $stable(extMon1Level)[*3]) |-> ##[0:2] (extMon1State == extMon1Level);
  endproperty
  a_mon1_follow: assert property (p_mon1_follow)
    else $error("first monitor state does not follow level");

  // Main scenarios reached.
  c_ready: cover property (measReadyIrq);
  c_mon2: cover property (extMon2Irq);
  c_pg_fall: cover property ($fell(stepUpPgState) && stepUpPgIrq);
endmodule : rail_regs_checker

bind rail_irq_mask_and_load_meas_regs rail_regs_checker chk_u (.mclk, .rst, .ce, .regReq,
  .measReadyIrqMask, .measRes, .measStart, .measConv, .measReadyIrq, .stepUpPgLevel,
  .stepUpCurlimLevel, .extMon1Level, .stepUpPgState, .stepUpCurlimState, .extMon1State,
  .analogSupplyState, .extMon2State, .stepUpPgIrq, .stepUpCurlimIrq, .analogSupplyIrq,
  .extMon1Irq, .extMon2Irq);
`default_nettype wire

/* verif/meas_engine_model.sv */
// Purpose: Behavioural load-current measurement engine.
// Assumes: Latency is at least one cycle.
// Notes: The value line is scrambled between answers, as nothing holds it.
`timescale 1ns/100ps
`default_nettype none
module meas_engine_model #(
  parameter logic [8:0] VAL0 = 9'h1a5,
  parameter logic [8:0] VAL1 = 9'h05a
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Start request and answer delay.
  input wire logic measStart,
  input wire logic measConv,
  input wire logic [7:0] latency,
  // Answer towards the bank.
  output var rail_mask_pkg::meas_res_s measRes
);
  logic [7:0] cnt;
  logic conv;

  // A new start drops the running count, so only the last start answers.
  always_ff @(posedge mclk) begin
    measRes.done <= 1'b0;
    measRes.value <= ~measRes.value;
    if (rst) begin
      cnt <= 8'h00;
      measRes.value <= 9'h000;
    end else if (measStart) begin
      cnt <= latency;
      conv <= measConv;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) begin
        measRes.done <= 1'b1;
        measRes.value <= conv ? VAL1 : VAL0;
      end
    end
  end
endmodule : meas_engine_model
`default_nettype wire

/* verif/test_rail_irq_mask_and_load_meas_regs.sv */
// Purpose: Self-checking bench for the mask and load measurement bank.
// Assumes: Inputs change at the falling edge; ce is held high.
// Notes: Pulses are counted at the rising edge and checked per scenario.
`timescale 1ns/100ps
`default_nettype none
module test_rail_irq_mask_and_load_meas_regs;
  localparam logic [8:0] VAL0 = 9'h1a5;
  localparam logic [8:0] VAL1 = 9'h05a;
  logic mclk = 1'b0;
  logic rst, otpLoad, measReadyIrqMask, measStart, measConv, measReadyIrq, regHit;
  rail_mask_pkg::reg_req_s regReq;
  rail_mask_pkg::meas_res_s measRes;
  logic [7:0] otpBoostMask, otpMonitorMask, regRdata, latency;
  logic [4:0] lv, st, irq;
  int pc[5];
  int starts, readies, dones, badCount, checked;

  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;

  rail_irq_mask_and_load_meas_regs dut_u (.mclk(mclk), .rst(rst), .ce(1'b1), .regReq(regReq),
    .regRdata(regRdata), .regHit(regHit), .otpLoad(otpLoad), .otpBoostMask(otpBoostMask),
    .otpMonitorMask(otpMonitorMask), .stepUpPgLevel(lv[0]), .stepUpCurlimLevel(lv[1]),
    .analogSupplyLevel(lv[2]), .extMon1Level(lv[3]), .extMon2Level(lv[4]),
    .stepUpPgState(st[0]), .stepUpCurlimState(st[1]), .analogSupplyState(st[2]),
    .extMon1State(st[3]), .extMon2State(st[4]), .stepUpPgIrq(irq[0]), .stepUpCurlimIrq(irq[1]),
    .analogSupplyIrq(irq[2]), .extMon1Irq(irq[3]), .extMon2Irq(irq[4]),
    .measReadyIrqMask(measReadyIrqMask), .measRes(measRes), .measStart(measStart),
    .measConv(measConv), .measReadyIrq(measReadyIrq));

  meas_engine_model #(.VAL0(VAL0), .VAL1(VAL1)) eng_u (.mclk(mclk), .rst(rst),
    .measStart(measStart), .measConv(measConv), .latency(latency), .measRes(measRes));

  // Pulses last one cycle, so they are counted at every rising edge.
  always @(posedge mclk) begin
    for (int i = 0; i < 5; i++) if (irq[i] === 1'b1) pc[i]++;
    if (measStart === 1'b1) starts++;
    if (measReadyIrq === 1'b1) readies++;
    if (measRes.done === 1'b1) dones++;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Every access ends with an idle cycle, so no strobe is set twice at one time.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n = 1);
    regReq = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    cyc(n);
    regReq = '0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    regReq = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    regReq = '0;
    cyc(1);
    chk({1'b0, regRdata}, {1'b0, e}, "read data");
    chk(9'(regHit), 9'(h), "read hit");
  endtask : rd

  task automatic t_regs;
    for (int a = 8'h2c; a <= 8'h30; a++) rd(8'(a), 8'h00, 1'b1);
    rd(8'h31, 8'h00, 1'b0);
    wr(8'h2c, 8'hff);
    wr(8'h2d, 8'hff);
    wr(8'h2f, 8'hff);
    rd(8'h2c, 8'hff, 1'b1);
    rd(8'h2d, 8'hff, 1'b1);
    rd(8'h2f, 8'h00, 1'b1);
  endtask : t_regs

  task automatic t_otp;
    otpBoostMask = 8'h0d;
    otpMonitorMask = 8'h2a;
    otpLoad = 1'b1;
    cyc(1);
    otpLoad = 1'b0;
    cyc(1);
    rd(8'h2c, 8'h0d, 1'b1);
    rd(8'h2d, 8'h2a, 1'b1);
    chk(9'(st[4]), 9'h001, "state of rail good at reset");
    chk(9'(pc[4]), 9'h000, "pulse after reset");
    lv[4] = 1'b0;
    cyc(8);
    chk(9'(st[4]), 9'h000, "state after masked fall");
    chk(9'(pc[4]), 9'h000, "fall pulse under loaded mask");
  endtask : t_otp

  // Each channel: no mask, rise mask, fall mask; the state must move every time.
  task automatic t_edges(input int ch, input logic [7:0] a, input int rb, input int fb, input logic hf);
    logic [7:0] mk;
    for (int m = 0; m < 3; m++) begin
      mk = (m == 1) ? 8'h01 << rb : (m == 2) ? 8'h01 << fb : 8'h00;
      wr(a, mk);
      pc[ch] = 0;
      lv[ch] = 1'b1;
      cyc(8);
      chk(9'(st[ch]), 9'h001, "state after rise");
      chk(9'(pc[ch]), 9'(!mk[rb]), "rise pulses");
      pc[ch] = 0;
      lv[ch] = 1'b0;
      cyc(8);
      chk(9'(st[ch]), 9'h000, "state after fall");
      chk(9'(pc[ch]), 9'(hf && !mk[fb]), "fall pulses");
    end
    wr(a, 8'h00);
  endtask : t_edges

  task automatic t_meas(input logic [7:0] d, input logic [7:0] lat, input logic msk, input logic [8:0] v);
    starts = 0;
    readies = 0;
    dones = 0;
    latency = lat;
    measReadyIrqMask = msk;
    wr(8'h2e, d);
    cyc(2);
    chk(9'(measConv), 9'(d[0]), "converter");
    chk(9'(starts), 9'h001, "starts");
    for (int i = 0; i < 300 && dones == 0; i++) cyc(1);
    cyc(2);
    chk(9'(readies), 9'(!msk), "ready pulses");
    rd(8'h2f, {7'h00, v[8]}, 1'b1);
    rd(8'h30, v[7:0], 1'b1);
  endtask : t_meas

  // Two writes of an unchanged value on a slow engine; the old result stays meanwhile.
  task automatic t_hold;
    starts = 0;
    readies = 0;
    dones = 0;
    latency = 8'h40;
    measReadyIrqMask = 1'b0;
    wr(8'h2e, 8'h00, 2);
    rd(8'h30, VAL1[7:0], 1'b1);
    rd(8'h2f, {7'h00, VAL1[8]}, 1'b1);
    for (int i = 0; i < 300 && dones == 0; i++) cyc(1);
    cyc(2);
    chk(9'(starts), 9'h002, "restarts");
    chk(9'(readies), 9'h001, "ready after restart");
    rd(8'h30, VAL0[7:0], 1'b1);
  endtask : t_hold

  task automatic completeRun;
    if (badCount == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : completeRun

  // Main sequence after a four-cycle reset.
  initial begin
    rst = 1'b1;
    regReq = '0;
    otpLoad = 1'b0;
    otpBoostMask = 8'h00;
    otpMonitorMask = 8'h00;
    lv = 5'h10;
    measReadyIrqMask = 1'b0;
    latency = 8'h04;
    cyc(4);
    rst = 1'b0;
    t_regs;
    t_otp;
    t_edges(0, 8'h2c, 2, 3, 1'b1);
    t_edges(1, 8'h2c, 0, 0, 1'b0);
    t_edges(2, 8'h2d, 0, 1, 1'b1);
    t_edges(3, 8'h2d, 2, 3, 1'b1);
    t_edges(4, 8'h2d, 4, 5, 1'b1);
    t_meas(8'h02, 8'h05, 1'b0, VAL0);
    t_meas(8'h03, 8'h09, 1'b1, VAL1);
    t_hold;
    completeRun;
  end

  // Watchdog well beyond the few hundred cycles the run needs.
  initial begin
    #100000;
    badCount++;
    completeRun;
  end
endmodule : test_rail_irq_mask_and_load_meas_regs
`default_nettype wire
